// File: design/timing_controller_pkg.sv
package timing_controller_pkg;

    // ****************************************************************
    // I/O port addresses
    // ****************************************************************
    localparam logic [15:0] MONO_INDEX_ADDR  = 16'h03b4;
    localparam logic [15:0] MONO_DATA_ADDR   = 16'h03b5;
    localparam logic [15:0] COLOR_INDEX_ADDR = 16'h03d4;
    localparam logic [15:0] COLOR_DATA_ADDR  = 16'h03d5;

    // ****************************************************************
    // Register indices and fields
    // ****************************************************************
    localparam logic [6:0] IDX_HORIZ_TOTAL  = 7'h00;
    localparam logic [6:0] IDX_ACTIVE_END   = 7'h01;
    localparam logic [6:0] IDX_PROTECT_CTRL = 7'h11;
    localparam logic [6:0] IDX_GROUP0_LAST  = 7'h07;
    localparam int         PROTECT_BIT      = 7;
    localparam int         INDEX_RSVD_BIT   = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [6:0] INDEX_RESET      = 7'h00;
    localparam logic [7:0] HTOTAL_RESET     = 8'h00;
    localparam logic [7:0] ACTIVE_END_RESET = 8'h00;
    localparam logic       PROTECT_RESET    = 1'b0;
    localparam logic [7:0] RDATA_RESET      = 8'h00;

    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam logic [8:0] HTOTAL_BIAS      = 9'h005;
    localparam logic [8:0] COUNT_RESET      = 9'h000;

    typedef struct packed {
        logic [7:0] total;
        logic [7:0] active_end;
    } htiming_cfg_s;

endpackage

// File: design/h_char_counter.sv
`timescale 1ns/1ps
module h_char_counter
    import timing_controller_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire htiming_cfg_s cfg,
    input  wire logic         centered_mode,
    input  wire logic         vertical_active,
    output logic [8:0]        count_ff,
    output logic              display_enable_ff,
    output logic              fetch_enable_ff,
    output logic              line_start_ff
);

    // ****************************************************************
    // Character counter and display enable
    // ****************************************************************
    // The last count is total plus four, so a line lasts total plus five clocks.
    wire logic [8:0] last_count = {1'b0, cfg.total} + HTOTAL_BIAS - 9'h001;
    // Compare with >= so a total shortened mid-line still wraps at once.
    wire logic       wrap       = (count_ff >= last_count);
    wire logic       run        = !centered_mode;
    wire logic [8:0] nxt_count  = (!run || wrap) ? COUNT_RESET : count_ff + 9'h001;
    logic            line_vact_ff;
    wire logic       nxt_vact   = wrap ? vertical_active : line_vact_ff;
    wire logic       nxt_de     = run && nxt_vact && (nxt_count <= {1'b0, cfg.active_end})
                                  && (nxt_count < last_count);
    wire logic       nxt_fetch  = run && (cfg.total != 8'h00);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_ff          <= COUNT_RESET;
            line_vact_ff      <= 1'b0;
            display_enable_ff <= 1'b0;
            fetch_enable_ff   <= 1'b0;
            line_start_ff     <= 1'b0;
        end else begin
            count_ff          <= nxt_count;
            line_vact_ff      <= nxt_vact;
            display_enable_ff <= nxt_de;
            fetch_enable_ff   <= nxt_fetch;
            line_start_ff     <= run && wrap;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_count_wrap: assert property (@(posedge clk) disable iff (reset)
        (!centered_mode && count_ff >= last_count && $stable(cfg))
            |=> (count_ff == 9'h000))
        else $error("character counter did not wrap at total plus five");
    a_count_step: assert property (@(posedge clk) disable iff (reset)
        (!centered_mode && count_ff < last_count) |=> (count_ff == $past(count_ff) + 9'h001))
        else $error("character counter did not advance by one");
    a_de_bound: assert property (@(posedge clk) disable iff (reset)
        display_enable_ff |-> (count_ff <= {1'b0, $past(cfg.active_end)}))
        else $error("display enable past programmed end");
    a_de_not_last: assert property (@(posedge clk) disable iff (reset)
        (display_enable_ff && $stable(cfg)) |-> (count_ff != last_count))
        else $error("display enable on last character");
    a_de_line_start: assert property (@(posedge clk) disable iff (reset)
        (!centered_mode && wrap && vertical_active && cfg.total != 8'h00)
            |=> display_enable_ff)
        else $error("display enable missing at start of active line");
    a_fetch_stop: assert property (@(posedge clk) disable iff (reset)
        (cfg.total == 8'h00) |=> !fetch_enable_ff)
        else $error("fetch enabled with zero horizontal total");

endmodule // h_char_counter

// File: design/legacy_timing_controller_horiz_timing.sv
`timescale 1ns/1ps
// Summary of operation
// - Index register sits at 3B4h in mono emulation, 3D4h in color emulation.
// - Data port sits at 3B5h or 3D5h, chosen by the emulation select bit.
// - Index bits six to zero pick the register reached through the data port.
// - Index bit seven is reserved and always reads back as zero.
// - Protect bit blocks writes to timing registers zero through seven.
// - Only group zero protection exists; no other protection group acts.
// - Native modes use registers as timing; centered modes use them as image size.
// - A horizontal total of zero stops display data fetching.
// - Display enable rises at every line start within vertical active region.
// - Display enable falls at active end or horizontal total, whichever first.
// - Oversized active end keeps enable on for all but the last character.
module legacy_timing_controller_horiz_timing
    import timing_controller_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        color_emulation,
    input  wire logic        centered_mode,
    input  wire logic        vertical_active,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata_ff,
    output logic             io_rdata_valid_ff,
    output logic      [8:0]  h_count,
    output logic             h_display_enable,
    output logic             fetch_enable,
    output logic             line_start,
    output logic      [7:0]  image_total_ff,
    output logic      [7:0]  image_active_end_ff,
    output logic             write_protect_ff
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic port_match(input logic [15:0] addr,
                                        input logic        color,
                                        input logic        data_port);
        logic [15:0] base;
        base = color ? (data_port ? COLOR_DATA_ADDR : COLOR_INDEX_ADDR)
                     : (data_port ? MONO_DATA_ADDR  : MONO_INDEX_ADDR);
        return addr == base;
    endfunction

    logic [6:0] index_ff;
    logic [7:0] htotal_ff;
    logic [7:0] active_end_ff;

    wire logic index_hit = port_match(io_addr, color_emulation, 1'b0);
    wire logic data_hit  = port_match(io_addr, color_emulation, 1'b1);
    // Only indices up to seven fall in the protected group; nothing else is guarded.
    wire logic group0    = (index_ff <= IDX_GROUP0_LAST);
    wire logic data_wr   = io_wr && data_hit;
    wire logic g0_wr_ok  = data_wr && !(write_protect_ff && group0);
    wire logic wr_total  = g0_wr_ok && (index_ff == IDX_HORIZ_TOTAL);
    wire logic wr_end    = g0_wr_ok && (index_ff == IDX_ACTIVE_END);
    wire logic wr_prot   = data_wr && (index_ff == IDX_PROTECT_CTRL);

    wire logic [6:0] nxt_index      = (io_wr && index_hit) ? io_wdata[6:0] : index_ff;
    wire logic [7:0] nxt_htotal     = wr_total ? io_wdata : htotal_ff;
    wire logic [7:0] nxt_active_end = wr_end ? io_wdata : active_end_ff;
    wire logic       nxt_protect    = wr_prot ? io_wdata[PROTECT_BIT] : write_protect_ff;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [7:0] data_value =
        (index_ff == IDX_HORIZ_TOTAL)  ? htotal_ff :
        (index_ff == IDX_ACTIVE_END)   ? active_end_ff :
        (index_ff == IDX_PROTECT_CTRL) ? {write_protect_ff, 7'h00} : 8'h00;
    wire logic       rd_hit    = io_rd && (index_hit || data_hit);
    // Reads of unmapped ports leave the last read data in place and give no valid.
    wire logic [7:0] nxt_rdata = !rd_hit ? io_rdata_ff :
                                 index_hit ? {1'b0, index_ff} : data_value;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            index_ff          <= INDEX_RESET;
            htotal_ff         <= HTOTAL_RESET;
            active_end_ff     <= ACTIVE_END_RESET;
            write_protect_ff  <= PROTECT_RESET;
            io_rdata_ff       <= RDATA_RESET;
            io_rdata_valid_ff <= 1'b0;
        end else begin
            index_ff          <= nxt_index;
            htotal_ff         <= nxt_htotal;
            active_end_ff     <= nxt_active_end;
            write_protect_ff  <= nxt_protect;
            io_rdata_ff       <= nxt_rdata;
            io_rdata_valid_ff <= rd_hit;
        end
    end

    // ****************************************************************
    // Image size seen by the centering logic
    // ****************************************************************
    // In centered modes only these size values matter; the local counter is held.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            image_total_ff      <= HTOTAL_RESET;
            image_active_end_ff <= ACTIVE_END_RESET;
        end else begin
            image_total_ff      <= htotal_ff;
            image_active_end_ff <= active_end_ff;
        end
    end

    // ****************************************************************
    // Horizontal timing
    // ****************************************************************
    wire htiming_cfg_s cfg = '{total: htotal_ff, active_end: active_end_ff};

    h_char_counter u_counter (
        .clk               (clk),
        .reset             (reset),
        .cfg               (cfg),
        .centered_mode     (centered_mode),
        .vertical_active   (vertical_active),
        .count_ff          (h_count),
        .display_enable_ff (h_display_enable),
        .fetch_enable_ff   (fetch_enable),
        .line_start_ff     (line_start)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_protect_blocks: assert property (@(posedge clk) disable iff (reset)
        (data_wr && write_protect_ff && group0) |=> ($stable(htotal_ff) && $stable(active_end_ff)))
        else $error("protected register was written");
    a_index_top_zero: assert property (@(posedge clk) disable iff (reset)
        (io_rd && index_hit) |=> (io_rdata_valid_ff && !io_rdata_ff[INDEX_RSVD_BIT]))
        else $error("index reserved bit read as one");
    a_total_write: assert property (@(posedge clk) disable iff (reset)
        (data_wr && !write_protect_ff && index_ff == IDX_HORIZ_TOTAL)
            |=> (htotal_ff == $past(io_wdata)))
        else $error("horizontal total write lost");
    a_wrong_port: assert property (@(posedge clk) disable iff (reset)
        (io_wr && !data_hit) |=> ($stable(htotal_ff) && $stable(active_end_ff)))
        else $error("data write taken at wrong port");
    a_index_port: assert property (@(posedge clk) disable iff (reset)
        (io_wr && index_hit) |=> (index_ff == $past(io_wdata[6:0])))
        else $error("index write at selected port not taken");
    a_other_group: assert property (@(posedge clk) disable iff (reset)
        (data_wr && index_ff == IDX_PROTECT_CTRL)
            |=> (write_protect_ff == $past(io_wdata[PROTECT_BIT])))
        else $error("protection control write blocked");

    // ****************************************************************
    // Read path checks
    // ****************************************************************
    a_index_read: assert property (@(posedge clk) disable iff (reset)
        (io_rd && index_hit)
            |=> (io_rdata_ff == {1'b0, $past(index_ff)}))
        else $error("index read returned wrong value");
    a_total_read: assert property (@(posedge clk) disable iff (reset)
        (io_rd && data_hit && index_ff == IDX_HORIZ_TOTAL)
            |=> (io_rdata_ff == $past(htotal_ff)))
        else $error("horizontal total read returned wrong value");
    a_end_read: assert property (@(posedge clk) disable iff (reset)
        (io_rd && data_hit && index_ff == IDX_ACTIVE_END)
            |=> (io_rdata_ff == $past(active_end_ff)))
        else $error("active end read returned wrong value");
    a_protect_read: assert property (@(posedge clk) disable iff (reset)
        (io_rd && data_hit && index_ff == IDX_PROTECT_CTRL)
            |=> (io_rdata_ff == {$past(write_protect_ff), 7'h00}))
        else $error("protection control read returned wrong value");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
        (io_rd && data_hit && index_ff != IDX_HORIZ_TOTAL && index_ff != IDX_ACTIVE_END
            && index_ff != IDX_PROTECT_CTRL) |=> (io_rdata_ff == 8'h00))
        else $error("unimplemented register read not zero");
    a_data_valid: assert property (@(posedge clk) disable iff (reset)
        (io_rd && data_hit)
            |=> io_rdata_valid_ff)
        else $error("data port read gave no valid");
    a_miss_no_valid: assert property (@(posedge clk) disable iff (reset)
        (!(io_rd && (index_hit || data_hit)))
            |=> !io_rdata_valid_ff)
        else $error("valid given without a read of a selected port");
    a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
        (!(io_rd && (index_hit || data_hit)))
            |=> $stable(io_rdata_ff))
        else $error("read data changed without a read");

    // ****************************************************************
    // Write path checks
    // ****************************************************************
    a_end_write: assert property (@(posedge clk) disable iff (reset)
        (data_wr && !write_protect_ff && index_ff == IDX_ACTIVE_END)
            |=> (active_end_ff == $past(io_wdata)))
        else $error("active end write lost");
    a_end_protect: assert property (@(posedge clk) disable iff (reset)
        (data_wr && write_protect_ff && index_ff == IDX_ACTIVE_END)
            |=> $stable(active_end_ff))
        else $error("protected active end was written");
    a_index_hold: assert property (@(posedge clk) disable iff (reset)
        (!(io_wr && index_hit))
            |=> $stable(index_ff))
        else $error("index changed without an index port write");
    a_total_hold: assert property (@(posedge clk) disable iff (reset)
        (!(data_wr && index_ff == IDX_HORIZ_TOTAL))
            |=> $stable(htotal_ff))
        else $error("horizontal total changed without a write");
    a_end_hold: assert property (@(posedge clk) disable iff (reset)
        (!(data_wr && index_ff == IDX_ACTIVE_END))
            |=> $stable(active_end_ff))
        else $error("active end changed without a write");
    a_protect_hold: assert property (@(posedge clk) disable iff (reset)
        (!(data_wr && index_ff == IDX_PROTECT_CTRL))
            |=> $stable(write_protect_ff))
        else $error("protect bit changed without a write");
    a_image_copy: assert property (@(posedge clk) disable iff (reset)
        (image_total_ff == $past(htotal_ff))
            && (image_active_end_ff == $past(active_end_ff)))
        else $error("image size copy out of step");

endmodule // legacy_timing_controller_horiz_timing

// File: sim/pixel_sink.sv
`timescale 1ns/1ps
module pixel_sink (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       h_display_enable,
    input  wire logic       line_start,
    output logic      [8:0] active_len_ff,
    output logic      [8:0] line_len_ff
);
    // ****************************************************************
    // Line measurement
    // ****************************************************************
    // The sink only measures and never stalls, so any line shape is taken as it comes.
    logic [8:0] run_ff;
    logic [8:0] cyc_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_ff        <= 9'h000;
            cyc_ff        <= 9'h000;
            active_len_ff <= 9'h000;
            line_len_ff   <= 9'h000;
        end else if (line_start) begin
            active_len_ff <= run_ff;
            line_len_ff   <= cyc_ff;
            run_ff        <= {8'h00, h_display_enable};
            cyc_ff        <= 9'h001;
        end else begin
            run_ff        <= run_ff + {8'h00, h_display_enable};
            cyc_ff        <= cyc_ff + 9'h001;
        end
    end
endmodule // pixel_sink

// File: sim/legacy_timing_controller_horiz_timing_bench.sv
`timescale 1ns/1ps
module legacy_timing_controller_horiz_timing_bench
    import timing_controller_pkg::*;
;
    // ****************************************************************
    // Stimulus and instances
    // ****************************************************************
    logic clk = 1'b0, reset = 1'b1, color_emulation = 1'b0, centered_mode = 1'b0;
    logic vertical_active = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000, ix_a = MONO_INDEX_ADDR, dp_a = MONO_DATA_ADDR;
    logic [7:0]  io_wdata = 8'h00, io_rdata_ff, image_total_ff, image_active_end_ff;
    logic [8:0]  h_count, active_len_ff, line_len_ff;
    logic        io_rdata_valid_ff, h_display_enable, fetch_enable, line_start, write_protect_ff;
    int          n_fail = 0, num_checks = 0;
    always #10 clk = ~clk;
    legacy_timing_controller_horiz_timing dut_u (.clk(clk), .reset(reset), .color_emulation(color_emulation),
        .centered_mode(centered_mode), .vertical_active(vertical_active), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
        .io_rdata_valid_ff(io_rdata_valid_ff), .h_count(h_count),
        .h_display_enable(h_display_enable), .fetch_enable(fetch_enable),
        .line_start(line_start), .image_total_ff(image_total_ff),
        .image_active_end_ff(image_active_end_ff), .write_protect_ff(write_protect_ff));
    pixel_sink sink_u (.clk(clk), .reset(reset), .h_display_enable(h_display_enable),
        .line_start(line_start), .active_len_ff(active_len_ff), .line_len_ff(line_len_ff));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a; io_wdata <= d; io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0; io_wdata <= ~d;
    endtask
    task automatic io_read(input logic [15:0] a, input logic [7:0] exp, input logic vld);
        @(posedge clk);
        io_addr <= a; io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        check({8'h00, io_rdata_valid_ff}, {8'h00, vld});
        if (vld) check({1'b0, io_rdata_ff}, {1'b0, exp});
    endtask
    task automatic reg_rw(input logic [6:0] i, input logic [7:0] d, input logic [7:0] exp);
        io_write(ix_a, {1'b0, i});
        io_write(dp_a, d);
        io_read(dp_a, exp, 1'b1);
    endtask
    task automatic line_chk(input logic [7:0] t, input logic [7:0] e, input logic [8:0] act);
        reg_rw(IDX_HORIZ_TOTAL, t, t);
        reg_rw(IDX_ACTIVE_END, e, e);
        repeat (80) @(posedge clk);
        #1;
        check(line_len_ff, {1'b0, t} + HTOTAL_BIAS);
        check(active_len_ff, act);
        check({8'h00, fetch_enable}, {8'h00, t != 8'h00});
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        io_read(ix_a, 8'h00, 1'b1);
        io_read(dp_a, HTOTAL_RESET, 1'b1);
        io_write(ix_a, 8'hff);
        io_read(ix_a, 8'h7f, 1'b1);
        io_read(COLOR_INDEX_ADDR, 8'h00, 1'b0);
        reg_rw(IDX_HORIZ_TOTAL, 8'h10, 8'h10);
        io_write(COLOR_DATA_ADDR, 8'h22);
        io_read(dp_a, 8'h10, 1'b1);
        @(posedge clk);
        color_emulation <= 1'b1;
        ix_a = COLOR_INDEX_ADDR;
        dp_a = COLOR_DATA_ADDR;
        io_read(MONO_DATA_ADDR, 8'h00, 1'b0);
        line_chk(8'h00, 8'h02, 9'h003);
        line_chk(8'h10, 8'h03, 9'h004);
        line_chk(8'h10, 8'hff, 9'h014);
        reg_rw(IDX_PROTECT_CTRL, 8'h80, 8'h80);
        check({8'h00, write_protect_ff}, 9'h001);
        reg_rw(IDX_ACTIVE_END, 8'h05, 8'hff);
        reg_rw(IDX_HORIZ_TOTAL, 8'h22, 8'h10);
        reg_rw(IDX_GROUP0_LAST, 8'h33, 8'h00);
        reg_rw(IDX_PROTECT_CTRL, 8'h00, 8'h00);
        reg_rw(IDX_ACTIVE_END, 8'h05, 8'h05);
        @(posedge clk);
        vertical_active <= 1'b0;
        repeat (80) @(posedge clk);
        #1;
        check(active_len_ff, 9'h000);
        @(posedge clk);
        vertical_active <= 1'b1;
        centered_mode <= 1'b1;
        repeat (30) @(posedge clk);
        #1;
        check(h_count, COUNT_RESET);
        check({8'h00, h_display_enable}, 9'h000);
        check({1'b0, image_total_ff}, 9'h010);
        check({1'b0, image_active_end_ff}, 9'h005);
        give_verdict;
    end
endmodule // legacy_timing_controller_horiz_timing_bench
